// File: rtl/eeprom_array_control_regs.sv
// Purpose: control, configuration and timebase registers of a 512-byte
//          eeprom array, with latching, protection and cycle control
// Assumes: nonvolatile shadow bytes arrive on nv_* inputs; ref_clk_en is
//          a one-cycle pulse per selected reference clock period
// Notes:   first access may follow the first edge after reset release
`timescale 1ns/1ps
`include "eeprom_map.svh"
module eeprom_array_control_regs #(
    parameter logic [15:0] PGM_TICKS = 16'(`PGM_TIME_US / `TIMEBASE_US)
) (
    input logic clk,
    input logic rst_n,
    input logic [15:0] addr,
    input logic [7:0] wdata,
    input logic wr_en,
    input logic rd_en,
    output logic [7:0] rdata,
    input logic [7:0] array_rdata,
    input logic [7:0] nv_config,
    input logic [7:0] nv_div_high,
    input logic [7:0] nv_div_low,
    input logic ref_clk_en,
    input logic stop_mode,
    output logic array_power_down,
    output logic [1:0] program_mode,
    output logic latch_active,
    output logic hv_enable,
    output logic [1:0] hv_target,
    output logic [8:0] latched_addr,
    output logic [7:0] latched_data
);
    eeprom_pkg::ctl_state_t s;
    eeprom_pkg::ctl_state_t next_s;
    eeprom_timer_if t ();

    logic in_arr;
    logic in_sec;
    logic [8:0] off;
    logic [3:0] bp;
    logic sec_on;
    logic arr_ok;
    logic lat_idle;
    logic div_wr_ok;
    logic cfg_nv_ok;
    logic div_nv_ok;

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    assign t.divisor = {s.divh[2:0], s.divl};
    assign t.ref_en = ref_clk_en;
    assign t.run = s.ctrl[`CTRL_PGM] && s.ctrl[`CTRL_LAT];
    assign t.halt = stop_mode;

    eeprom_timebase u_timebase (
        .clk(clk),
        .rst_n(rst_n),
        .t(t)
    );

    eeprom_cycle_timer #(
        .PGM_TICKS(PGM_TICKS)
    ) u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .t(t)
    );

    // ----------------------------------------------------------------
    // address decode and protection
    // ----------------------------------------------------------------
    assign in_arr = (addr >= `ARR_FIRST) && (addr <= `ARR_LAST);
    assign in_sec = (addr >= `SEC_FIRST) && (addr <= `SEC_LAST);
    assign off = 9'(addr - `ARR_FIRST);
    assign bp = s.cfg[`CFG_BP_MSB:`CFG_BP_LSB];
    assign sec_on = !s.cfg[`CFG_SEC_N];
    // protected block, secured range and multi-byte erase under security all refuse
    assign arr_ok = !bp[off[8:7]]
        && !(sec_on && in_sec)
        && !(sec_on && s.ctrl[`CTRL_RAS1]);
    assign lat_idle = s.ctrl[`CTRL_LAT] && !s.ctrl[`CTRL_PGM];
    // divider halves are frozen while latched or while the lock is armed
    assign div_wr_ok = !s.ctrl[`CTRL_LAT] && s.divh[`DIVH_LOCK_DIS];
    assign cfg_nv_ok = !sec_on;
    assign div_nv_ok = s.divh[`DIVH_LOCK_DIS];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (!s.loaded) begin
            // shadows copied on the first edge after reset; strobes dropped
            next_s.cfg = nv_config;
            next_s.divh = nv_div_high & `DIVH_MASK;
            next_s.divl = nv_div_low;
            next_s.loaded = 1'b1;
        end else begin
            if (wr_en) begin
                case (addr)
                    `OFF_CTRL: begin
                        next_s.ctrl = wdata;
                        // latch stays while enable was set, so the pump can discharge
                        if (s.ctrl[`CTRL_PGM] && !wdata[`CTRL_LAT]) begin
                            next_s.ctrl[`CTRL_LAT] = 1'b1;
                        end
                        if (!(s.ctrl[`CTRL_LAT] && s.valid)) begin
                            next_s.ctrl[`CTRL_PGM] = 1'b0;
                        end
                    end
                    `OFF_CFG: begin
                        next_s.cfg = (s.cfg & ~`CFG_SPARE_MASK)
                            | (wdata & `CFG_SPARE_MASK);
                    end
                    `OFF_DIVH: begin
                        if (div_wr_ok) begin
                            next_s.divh = wdata & `DIVH_MASK;
                        end
                    end
                    `OFF_DIVL: begin
                        if (div_wr_ok) begin
                            next_s.divl = wdata;
                        end
                    end
                    `OFF_CFG_NV: begin
                        if (lat_idle) begin
                            next_s.target = eeprom_pkg::TGT_CFG;
                            next_s.lat_addr = 9'h000;
                            next_s.lat_data = wdata;
                            next_s.valid = cfg_nv_ok;
                        end
                    end
                    `OFF_DIVH_NV: begin
                        if (lat_idle) begin
                            next_s.target = eeprom_pkg::TGT_DIVH;
                            next_s.lat_addr = 9'h000;
                            next_s.lat_data = wdata;
                            next_s.valid = div_nv_ok;
                        end
                    end
                    `OFF_DIVL_NV: begin
                        if (lat_idle) begin
                            next_s.target = eeprom_pkg::TGT_DIVL;
                            next_s.lat_addr = 9'h000;
                            next_s.lat_data = wdata;
                            next_s.valid = div_nv_ok;
                        end
                    end
                    default: begin
                        if (in_arr && lat_idle) begin
                            next_s.target = eeprom_pkg::TGT_ARRAY;
                            next_s.lat_addr = off;
                            next_s.lat_data = wdata;
                            next_s.valid = arr_ok;
                        end
                    end
                endcase
            end
            if (rd_en) begin
                case (addr)
                    `OFF_CTRL: next_s.rdata = s.ctrl;
                    `OFF_CFG: next_s.rdata = s.cfg;
                    `OFF_DIVH: next_s.rdata = s.divh;
                    `OFF_DIVL: next_s.rdata = s.divl;
                    `OFF_CFG_NV: next_s.rdata = nv_config;
                    `OFF_DIVH_NV: next_s.rdata = nv_div_high;
                    `OFF_DIVL_NV: next_s.rdata = nv_div_low;
                    default: begin
                        if (in_arr && s.ctrl[`CTRL_LAT]) begin
                            next_s.rdata = s.lat_data;
                            if (!s.ctrl[`CTRL_PGM]) begin
                                next_s.target = eeprom_pkg::TGT_ARRAY;
                                next_s.lat_addr = off;
                                next_s.valid = arr_ok;
                            end
                        end else if (in_arr) begin
                            next_s.rdata = array_rdata;
                        end
                    end
                endcase
            end
            if (t.done && s.ctrl[`CTRL_AUTO]) begin
                next_s.ctrl[`CTRL_PGM] = 1'b0;
            end
            if (!next_s.ctrl[`CTRL_LAT]) begin
                next_s.valid = 1'b0;
            end
        end
        // stop drops the pump at once; the cycle timer restarts on exit
        next_s.hv = next_s.ctrl[`CTRL_PGM] && next_s.ctrl[`CTRL_LAT]
            && !stop_mode;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            // array reads as unprotected until the shadow byte is loaded
            s.cfg <= `CFG_FACTORY;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata = s.rdata;
    assign array_power_down = s.ctrl[`CTRL_OFF];
    assign program_mode = s.ctrl[`CTRL_RAS1:`CTRL_RAS0];
    assign latch_active = s.ctrl[`CTRL_LAT];
    assign hv_enable = s.hv;
    assign hv_target = s.target;
    assign latched_addr = s.lat_addr;
    assign latched_data = s.lat_data;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_clear_both;
        wr_en && addr == `OFF_CTRL && !wdata[`CTRL_LAT] && !wdata[`CTRL_PGM]
            && s.ctrl[`CTRL_PGM] && s.loaded;
    endsequence

    sequence s_auto_end;
        t.done && s.ctrl[`CTRL_AUTO] && s.loaded;
    endsequence

    sequence s_array_write;
        wr_en && in_arr && lat_idle && s.loaded;
    endsequence

    sequence s_div_shadow_write;
        wr_en && (addr == `OFF_DIVH_NV || addr == `OFF_DIVL_NV) && lat_idle && s.loaded;
    endsequence

    sequence s_first_load;
        $rose(s.loaded);
    endsequence

    a_pgm_needs_latch: assert property ($rose(s.ctrl[`CTRL_PGM]) |->
        $past(s.ctrl[`CTRL_LAT]) && $past(s.valid))
        else $error("enable set without a valid latched target");
    a_latch_held: assert property ($fell(s.ctrl[`CTRL_LAT]) |->
        !$past(s.ctrl[`CTRL_PGM]))
        else $error("latch cleared while enable was set");
    a_clear_both: assert property (s_clear_both |=>
        s.ctrl[`CTRL_LAT] && !s.ctrl[`CTRL_PGM])
        else $error("double clear did not keep the latch");
    a_spare_bit: assert property (wr_en && addr == `OFF_CTRL && s.loaded |=>
        s.ctrl[`CTRL_SPARE] == $past(wdata[`CTRL_SPARE]))
        else $error("spare control bit not stored");
    a_auto_clear: assert property (s_auto_end |=> !s.ctrl[`CTRL_PGM] && !hv_enable)
        else $error("auto end did not clear enable");
    a_no_auto_hold: assert property (
        t.done && s.ctrl[`CTRL_PGM] && !s.ctrl[`CTRL_AUTO] && !wr_en && s.loaded
        |=> s.ctrl[`CTRL_PGM])
        else $error("enable cleared without auto");
    a_hv_needs_both: assert property (hv_enable |->
        s.ctrl[`CTRL_PGM] && s.ctrl[`CTRL_LAT])
        else $error("high voltage without latch and enable");
    a_stop_no_hv: assert property (stop_mode |=> !hv_enable)
        else $error("high voltage during stop");
    a_div_locked: assert property (wr_en && s.loaded && !div_wr_ok
        && (addr == `OFF_DIVH || addr == `OFF_DIVL) |=> $stable(t.divisor)
        && $stable(s.divh))
        else $error("locked divider changed");
    a_div_accept: assert property (
        wr_en && addr == `OFF_DIVL && div_wr_ok && s.loaded |=> s.divl == $past(wdata))
        else $error("open divider write lost");
    a_cfg_readonly: assert property (wr_en && addr == `OFF_CFG && s.loaded |=>
        $stable(s.cfg[`CFG_SEC_N:`CFG_BP_LSB]))
        else $error("config protection field written");

    // ----------------------------------------------------------------
    // checks: protection, latching and reset load
    // ----------------------------------------------------------------
    a_secured_refuse: assert property (wr_en && in_arr && in_sec && sec_on
        && lat_idle && s.loaded |=> !s.valid)
        else $error("secured location accepted");
    a_block_refuse: assert property (s_array_write ##0 bp[off[8:7]] |=> !s.valid)
        else $error("protected block accepted");
    a_bulk_refuse: assert property (
        s_array_write ##0 (sec_on && s.ctrl[`CTRL_RAS1]) |=> !s.valid)
        else $error("block or bulk erase accepted under security");
    a_latch_replace: assert property (s_array_write |=>
        latched_addr == $past(off) && latched_data == $past(wdata)
        && hv_target == eeprom_pkg::TGT_ARRAY)
        else $error("array write did not replace the latch");
    a_latched_read: assert property (
        rd_en && in_arr && s.ctrl[`CTRL_LAT] && s.loaded |=> rdata == $past(s.lat_data))
        else $error("latched read returned other data");
    a_cfg_nv_target: assert property (
        wr_en && addr == `OFF_CFG_NV && lat_idle && s.loaded
        |=> hv_target == eeprom_pkg::TGT_CFG && latched_data == $past(wdata))
        else $error("config shadow write not latched");
    a_cfg_nv_locked: assert property (
        wr_en && addr == `OFF_CFG_NV && lat_idle && sec_on && s.loaded |=> !s.valid)
        else $error("secured config shadow accepted");
    a_shadow_locked: assert property (s_div_shadow_write ##0 !div_nv_ok |=> !s.valid)
        else $error("locked divider shadow accepted");
    a_config_load: assert property (s_first_load |-> s.cfg == $past(nv_config))
        else $error("config not loaded from shadow");
    a_divisor_load: assert property (s_first_load |->
        s.divl == $past(nv_div_low) && s.divh == ($past(nv_div_high) & `DIVH_MASK))
        else $error("divider not loaded from shadows");
    a_security_sticky: assert property (sec_on && s.loaded |=> !s.cfg[`CFG_SEC_N])
        else $error("security released");
endmodule

// File: rtl/eeprom_cycle_timer.sv
// Purpose: times one program or erase cycle in timebase ticks
// Assumes: tick comes from eeprom_timebase
// Notes:   a halt restarts the cycle from zero once released
`timescale 1ns/1ps
`include "eeprom_map.svh"
module eeprom_cycle_timer #(
    parameter logic [15:0] PGM_TICKS = 16'(`PGM_TIME_US / `TIMEBASE_US)
) (
    input logic clk,
    input logic rst_n,
    eeprom_timer_if.cyc t
);
    eeprom_pkg::cyc_state_t s;
    eeprom_pkg::cyc_state_t next_s;

    assign t.done = s.done;

    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            eeprom_pkg::CYC_IDLE: begin
                next_s.ticks = 16'h0000;
                if (t.run) begin
                    next_s.st = eeprom_pkg::CYC_RUN;
                end
            end
            eeprom_pkg::CYC_RUN: begin
                if (!t.run) begin
                    next_s.st = eeprom_pkg::CYC_IDLE;
                end else if (t.halt) begin
                    next_s.st = eeprom_pkg::CYC_HALT;
                end else if (t.tick) begin
                    if (s.ticks >= PGM_TICKS - 16'h0001) begin
                        next_s.done = 1'b1;
                        next_s.st = eeprom_pkg::CYC_END;
                    end else begin
                        next_s.ticks = s.ticks + 16'h0001;
                    end
                end
            end
            eeprom_pkg::CYC_HALT: begin
                next_s.ticks = 16'h0000;
                if (!t.run) begin
                    next_s.st = eeprom_pkg::CYC_IDLE;
                end else if (!t.halt) begin
                    next_s.st = eeprom_pkg::CYC_RUN;
                end
            end
            eeprom_pkg::CYC_END: begin
                if (!t.run) begin
                    next_s.st = eeprom_pkg::CYC_IDLE;
                end
            end
            default: begin
                next_s.st = eeprom_pkg::CYC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_done_only_running: assert property (s.done |-> $past(s.st) == eeprom_pkg::CYC_RUN
        && $past(t.tick) && !$past(t.halt))
        else $error("cycle ended while not running");
endmodule

// File: rtl/eeprom_map.svh
// Purpose: register offsets, field positions and timing figures of the
//          eeprom array control block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CTRL 16'h0000
`define OFF_CFG 16'h0001
`define OFF_CFG_NV 16'h0002
`define OFF_DIVH 16'h0003
`define OFF_DIVL 16'h0004
`define OFF_DIVH_NV 16'h0005
`define OFF_DIVL_NV 16'h0006

// ----------------------------------------------------------------
// array window and secured range
// ----------------------------------------------------------------
`define ARR_FIRST 16'h0800
`define ARR_LAST 16'h09ff
`define SEC_FIRST 16'h08f0
`define SEC_LAST 16'h08ff

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define CTRL_PGM 0
`define CTRL_AUTO 2
`define CTRL_LAT 3
`define CTRL_RAS0 4
`define CTRL_RAS1 5
`define CTRL_OFF 6
`define CTRL_SPARE 7
`define CFG_BP_MSB 3
`define CFG_BP_LSB 0
`define CFG_SEC_N 4
`define CFG_SPARE_MASK 8'he0
`define DIVH_LOCK_DIS 7
`define DIVH_MASK 8'h87
`define CFG_FACTORY 8'hf0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TIMEBASE_US 35
`define PGM_TIME_US 10000

`endif

// File: rtl/eeprom_pkg.sv
// Purpose: types shared by the eeprom array control modules
// Assumes: nothing
// Notes:   state of each module is one packed struct
package eeprom_pkg;

    typedef enum logic [1:0] {
        MODE_BYTE_PGM = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        TGT_ARRAY = 2'b00,
        TGT_CFG = 2'b01,
        TGT_DIVH = 2'b10,
        TGT_DIVL = 2'b11
    } target_t;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_RUN = 2'b01,
        CYC_HALT = 2'b10,
        CYC_END = 2'b11
    } cycle_state_t;

    typedef struct packed {
        logic [10:0] count;
        logic tick;
    } tb_state_t;

    typedef struct packed {
        cycle_state_t st;
        logic [15:0] ticks;
        logic done;
    } cyc_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] divh;
        logic [7:0] divl;
        logic loaded;
        logic valid;
        target_t target;
        logic [8:0] lat_addr;
        logic [7:0] lat_data;
        logic [7:0] rdata;
        logic hv;
    } ctl_state_t;

endpackage

// File: rtl/eeprom_timebase.sv
// Purpose: divides reference enable pulses into the program timebase tick
// Assumes: ref_en is a one-cycle pulse at the reference rate
// Notes:   count restarts whenever the cycle is not running or is halted
`timescale 1ns/1ps
module eeprom_timebase (
    input logic clk,
    input logic rst_n,
    eeprom_timer_if.base t
);
    eeprom_pkg::tb_state_t s;
    eeprom_pkg::tb_state_t next_s;
    logic [11:0] count_inc;

    assign count_inc = {1'b0, s.count} + 12'h001;
    assign t.tick = s.tick;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!t.run || t.halt) begin
            next_s.count = 11'h000;
        end else if (t.ref_en) begin
            if (count_inc >= {1'b0, t.divisor}) begin
                next_s.count = 11'h000;
                next_s.tick = 1'b1;
            end else begin
                next_s.count = count_inc[10:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tick_needs_ref: assert property (s.tick |-> $past(t.ref_en) && $past(t.run))
        else $error("timebase tick without reference pulse");
endmodule

// File: rtl/eeprom_timer_if.sv
// Purpose: carries divisor, run control and ticks between control and timers
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface eeprom_timer_if;
    logic [10:0] divisor;
    logic ref_en;
    logic run;
    logic halt;
    logic tick;
    logic done;
    modport ctl (output divisor, output ref_en, output run, output halt, input done);
    modport base (input divisor, input ref_en, input run, input halt, output tick);
    modport cyc (input tick, input run, input halt, output done);
endinterface

// File: test/tb_top.sv
// Purpose: self-checking bench for eeprom_array_control_regs
// Assumes: register offsets and bit positions from eeprom_map.svh
// Notes:   cycle length shortened to 3 ticks, divisor 2
`timescale 1ns/1ps
`include "eeprom_map.svh"
module tb_top;
    logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, ref_clk_en = 0, stop_mode = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, nv_config = 8'hf0, nv_div_high = 8'h80;
    logic [7:0] nv_div_low = 8'h02, array_rdata = 8'h5a, latched_data;
    logic array_power_down, latch_active, hv_enable;
    logic [1:0] program_mode, hv_target;
    logic [8:0] latched_addr;
    int mismatches = 0, comparisons = 0;
    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    localparam row_t rows[10] = '{
        '{`OFF_CTRL, 8'h80, 8'h80}, '{`OFF_CTRL, 8'h42, 8'h42},
        '{`OFF_CFG, 8'h0f, 8'h10}, '{`OFF_CFG, 8'he0, 8'hf0},
        '{`OFF_DIVL, 8'h05, 8'h05}, '{`OFF_DIVH, 8'hfc, 8'h84},
        '{`OFF_DIVH, 8'h80, 8'h80}, '{`OFF_DIVL, 8'h02, 8'h02},
        '{16'h0007, 8'haa, 8'h00}, '{`OFF_CTRL, 8'h00, 8'h00}};

    always #4 clk = ~clk;
    always @(posedge clk) ref_clk_en <= ~ref_clk_en;

    eeprom_array_control_regs #(.PGM_TICKS(16'h0003)) dut_u (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .array_rdata(array_rdata),
        .nv_config(nv_config), .nv_div_high(nv_div_high), .nv_div_low(nv_div_low),
        .ref_clk_en(ref_clk_en), .stop_mode(stop_mode),
        .array_power_down(array_power_down), .program_mode(program_mode),
        .latch_active(latch_active), .hv_enable(hv_enable), .hv_target(hv_target),
        .latched_addr(latched_addr), .latched_data(latched_data));

    // ----------------------------------------------------------------
    // bus tasks and checks
    // ----------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(9'(rdata), 9'(e));
    endtask

    task automatic wait_hv(input logic v);
        int n;
        n = 0;
        while (hv_enable !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            results();
        end
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFF_CTRL, 8'h00);
        chk(9'({array_power_down, program_mode, latch_active, hv_enable}), 9'h000);
        rd(`OFF_CFG, 8'hf0);
        rd(`OFF_DIVH, 8'h80);
        rd(`OFF_DIVL, 8'h02);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        for (int m = 0; m < 4; m++) begin
            wr(`OFF_CTRL, 8'(8'h40 | (m << 4)));
            @(negedge clk);
            chk(9'({array_power_down, program_mode}), 9'(4 | m));
        end
        wr(`OFF_CTRL, 8'h01);
        rd(`OFF_CTRL, 8'h00);
        wr(`OFF_CTRL, 8'h0c);
        @(negedge clk);
        chk(9'(latch_active), 9'h001);
        wr(`OFF_DIVH, 8'h81);
        rd(`OFF_DIVH, 8'h80);
        wr(16'h0823, 8'h3c);
        @(negedge clk);
        chk(latched_addr, 9'h023);
        chk(9'(latched_data), 9'h03c);
        rd(16'h0823, 8'h3c);
        wr(16'h0810, 8'h11);
        @(negedge clk);
        chk(latched_addr, 9'h010);
        wr(`OFF_CTRL, 8'h0d);
        @(negedge clk);
        chk(9'(hv_enable), 9'h001);
        @(posedge clk);
        stop_mode <= 1'b1;
        repeat (3) @(negedge clk);
        chk(9'(hv_enable), 9'h000);
        repeat (20) @(posedge clk);
        rd(`OFF_CTRL, 8'h0d);
        @(posedge clk);
        stop_mode <= 1'b0;
        wait_hv(1'b1);
        wait_hv(1'b0);
        rd(`OFF_CTRL, 8'h0c);
        wr(`OFF_CTRL, 8'h08);
        wr(`OFF_CFG_NV, 8'h55);
        @(negedge clk);
        chk(9'(hv_target), 9'h001);
        wr(`OFF_CTRL, 8'h09);
        repeat (40) @(negedge clk);
        chk(9'(hv_enable), 9'h001);
        wr(`OFF_CTRL, 8'h01);
        rd(`OFF_CTRL, 8'h09);
        wr(`OFF_CTRL, 8'h00);
        rd(`OFF_CTRL, 8'h08);
        wr(`OFF_CTRL, 8'h00);
        rd(`OFF_CTRL, 8'h00);
        rd(16'h0900, 8'h5a);
        wr(`OFF_CTRL, 8'h08);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h08);
        wr(`OFF_CTRL, 8'h00);
        // security armed, block 0 protected, divider lock armed
        @(posedge clk);
        nv_config <= 8'he1;
        nv_div_high <= 8'h78;
        do_reset();
        rd(`OFF_CFG, 8'he1);
        rd(`OFF_DIVH, 8'h00);
        wr(`OFF_DIVL, 8'h07);
        rd(`OFF_DIVL, 8'h02);
        wr(`OFF_CFG, 8'hff);
        rd(`OFF_CFG, 8'he1);
        wr(`OFF_CTRL, 8'h08);
        wr(`OFF_DIVL_NV, 8'h00);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h08);
        wr(`OFF_CFG_NV, 8'h00);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h08);
        wr(16'h0823, 8'h00);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h08);
        wr(16'h08f5, 8'h00);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h08);
        wr(`OFF_CTRL, 8'h28);
        wr(16'h0910, 8'h00);
        wr(`OFF_CTRL, 8'h29);
        rd(`OFF_CTRL, 8'h28);
        wr(`OFF_CTRL, 8'h08);
        wr(16'h0910, 8'h00);
        wr(`OFF_CTRL, 8'h09);
        rd(`OFF_CTRL, 8'h09);
        chk(9'(hv_enable), 9'h001);
        results();
    end
endmodule
